//--- hw/adc_seq_regs.vh
// constants for the continuous readout sequencer
// assumes the including file runs on a 125 MHz system clock
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// system clock period in ns
`define CLK_PERIOD_NS 8

// internal serial clock period in ns, derived from the conversion oscillator
`define SCK_PERIOD_NS 160
// half serial clock period in system clock cycles
`define SCK_HALF_CYC ((`SCK_PERIOD_NS / 2) / `CLK_PERIOD_NS)

// bits in one readout frame and rising edges that delimit it
`define FRAME_BITS 32
`define FRAME_EDGES 6'h20

// result bits that follow the end-of-conversion bit
`define RES_W 31

// reset value of the serial pins: both idle high
`define PIN_IDLE 1'b1

// front-end sampling period with the internal oscillator, in ns
`define SAMPLE_PERIOD_NS 8100
// sampling period in system clock cycles (rounded down)
`define SAMPLE_CYC (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

// external oscillator: sampling period of 2.5 cycles counted as 5 edges
`define EXT_SAMPLE_EDGES 3'h5

// cycles to wait after reset before the clock-pin strap is read
`define STRAP_WAIT 2'h3

`endif

//--- hw/result_buffer.v
// two-entry buffer between the conversion core and the readout sequencer
// assumes both sides sit on the same clock; ready is registered
`timescale 1ns/1ps

module result_buffer #(
   parameter WIDTH = 31
) (
   // clock and reset
   input wire i_clk,
   input wire i_reset,
   // filling side
   input wire [WIDTH-1:0] i_in_data,
   input wire i_in_valid,
   output reg o_in_ready,
   // draining side
   output wire [WIDTH-1:0] o_out_data,
   output wire o_out_valid,
   input wire i_out_ready
);

   reg [WIDTH-1:0] mem_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] count_reg;
   reg [1:0] count_next;
   wire push;
   wire pop;

   // a push while full is refused by ready, a pop while empty by valid
   assign push = i_in_valid && o_in_ready;
   assign pop = i_out_ready && (count_reg != 2'h0);
   assign o_out_valid = (count_reg != 2'h0);
   assign o_out_data = mem_reg[rd_ptr_reg];

   // occupancy after this cycle
   always @* begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 2'h1;
      end else if (pop && !push) begin
         count_next = count_reg - 2'h1;
      end
   end

   // storage, pointers and registered ready
   always @(posedge i_clk) begin
      if (i_reset) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
         o_in_ready <= 1'b0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_next;
         o_in_ready <= (count_next != 2'h2); // ready registered from the next count, so it is low while full and until the first clock after reset
      end
   end

endmodule // result_buffer

//--- hw/adc_readout_seq.v
// readout sequencer for internal serial clock, chip select grounded, continuous conversion
// assumes chip select is tied low outside; serial pins and oscillator come from other domains
// assumes results arrive on i_clk from logic in the same domain
`timescale 1ns/1ps
`include "adc_seq_regs.vh"

module adc_readout_seq (
   // clock and reset
   input wire i_clk,
   input wire i_reset,
   // conversion results from the core
   input wire [`RES_W-1:0] i_result_data,
   input wire i_result_valid,
   output wire o_result_ready,
   // serial clock pin, two-way
   input wire i_sck_in,
   output reg o_sck_out,
   output reg o_sck_oe,
   // serial data pins
   output reg o_sdo,
   input wire i_sdi,
   // conversion oscillator pins
   input wire i_conv_osc_input,
   input wire i_ext_osc_en,
   // status and received configuration
   output reg o_int_mode,
   output reg o_sleep,
   output reg o_sample_strobe,
   output reg o_cfg_valid,
   output reg [`FRAME_BITS-1:0] o_cfg_word
);

   // sequencer states
   // binary codes; S_EXT is a dead end that only a reset leaves
   localparam [2:0] S_STRAP = 3'h0;
   localparam [2:0] S_CONV = 3'h1;
   localparam [2:0] S_SLEEP = 3'h2;
   localparam [2:0] S_HIGH = 3'h3;
   localparam [2:0] S_LOW = 3'h4;
   localparam [2:0] S_EXT = 3'h5;

   // timing counts worked out at full width, then cut on purpose to their counters
   localparam [31:0] HALF_FULL = `SCK_HALF_CYC - 1;
   localparam [31:0] SAMPLE_FULL = `SAMPLE_CYC - 1;
   localparam [7:0] HALF_LAST = HALF_FULL[7:0];
   localparam [9:0] SAMPLE_LAST = SAMPLE_FULL[9:0];
   // last edge of a sampling period with the external oscillator
   localparam [2:0] EXT_LAST = `EXT_SAMPLE_EDGES - 3'h1;

   // synchronisers for the pins
   reg sck_meta_reg;
   reg sck_sync_reg;
   reg sdi_meta_reg;
   reg sdi_sync_reg;
   reg osc_meta_reg;
   reg osc_sync_reg;
   reg osc_dly_reg;
   reg ext_meta_reg;
   reg ext_sync_reg;

   // sequencer state
   reg [2:0] state_reg;
   reg [7:0] half_cnt_reg;
   reg [5:0] rise_cnt_reg;
   reg [1:0] strap_cnt_reg;
   reg [`FRAME_BITS-1:0] out_shift_reg;
   reg [`FRAME_BITS-1:0] in_shift_reg;

   // sampling clock state
   reg [9:0] sample_cnt_reg;
   reg [2:0] edge_cnt_reg;

   // buffer draining side, plus the decoded half-period, frame-end and oscillator-edge flags
   wire [`RES_W-1:0] buf_data;
   wire buf_valid;
   wire buf_pop;
   wire half_done;
   wire osc_edge;
   wire frame_last;

   // append one received bit, first bit ends up as the most significant
   function [`FRAME_BITS-1:0] shift_in;
      input [`FRAME_BITS-1:0] word;
      input bit_in;
      begin
         shift_in = {word[`FRAME_BITS-2:0], bit_in};
      end
   endfunction

   // results wait here while a frame is running, so a slow frame loses no word
   // the core may finish one result while another frame is still going out
   result_buffer #(
      .WIDTH(`RES_W)
   ) u_result_buffer (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_in_data(i_result_data),
      .i_in_valid(i_result_valid),
      .o_in_ready(o_result_ready),
      .o_out_data(buf_data),
      .o_out_valid(buf_valid),
      .i_out_ready(buf_pop)
   );

   // a waiting result ends the conversion phase
   assign buf_pop = (state_reg == S_CONV) && buf_valid;
   assign half_done = (half_cnt_reg == HALF_LAST);
   assign frame_last = (rise_cnt_reg == `FRAME_EDGES);

   // two flip-flops on every input from outside the clock domain
   // clock pin resets to its pulled-up idle level, so no false low is read at the strap
   always @(posedge i_clk) begin
      if (i_reset) begin
         sck_meta_reg <= `PIN_IDLE;
         sck_sync_reg <= `PIN_IDLE;
         sdi_meta_reg <= 1'b0;
         sdi_sync_reg <= 1'b0;
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
      end else begin
         sck_meta_reg <= i_sck_in;
         sck_sync_reg <= sck_meta_reg;
         sdi_meta_reg <= i_sdi;
         sdi_sync_reg <= sdi_meta_reg;
         osc_meta_reg <= i_conv_osc_input;
         osc_sync_reg <= osc_meta_reg;
         ext_meta_reg <= i_ext_osc_en;
         ext_sync_reg <= ext_meta_reg;
      end
   end

   // readout sequencer
   always @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= S_STRAP;
         half_cnt_reg <= 8'h00;
         rise_cnt_reg <= 6'h00;
         strap_cnt_reg <= 2'h0;
         out_shift_reg <= {`FRAME_BITS{1'b1}};
         in_shift_reg <= {`FRAME_BITS{1'b0}};
         o_sck_out <= `PIN_IDLE;
         o_sck_oe <= 1'b0;
         o_sdo <= `PIN_IDLE;
         o_int_mode <= 1'b1;
         o_sleep <= 1'b0;
         o_cfg_valid <= 1'b0;
         o_cfg_word <= {`FRAME_BITS{1'b0}};
      end else begin
         // pulse outputs fall back unless a state raises them this cycle
         o_cfg_valid <= 1'b0;
         case (state_reg)
            // let the synchroniser fill before the strap is read
            S_STRAP: begin
               strap_cnt_reg <= strap_cnt_reg + 2'h1;
               if (strap_cnt_reg == `STRAP_WAIT) begin
                  o_int_mode <= sck_sync_reg;
                  if (sck_sync_reg) begin
                     o_sck_oe <= 1'b1;
                     state_reg <= S_CONV;
                  end else begin
                     state_reg <= S_EXT;
                  end
               end
            end

            // converting: both pins high until the core hands over a result
            S_CONV: begin
               o_sck_out <= 1'b1;
               o_sdo <= 1'b1;
               if (buf_valid) begin
                  out_shift_reg <= {1'b0, buf_data};
                  o_sck_out <= 1'b0;
                  o_sdo <= 1'b0;
                  o_sleep <= 1'b1;
                  half_cnt_reg <= 8'h00;
                  state_reg <= S_SLEEP;
               end
            end

            // sleep for half a clock period, then the first rise with no request
            // the input is sampled on this first rise too, as on every later one
            S_SLEEP: begin
               half_cnt_reg <= half_cnt_reg + 8'h01;
               if (half_done) begin
                  o_sleep <= 1'b0;
                  o_sck_out <= 1'b1;
                  in_shift_reg <= shift_in(in_shift_reg, sdi_sync_reg);
                  rise_cnt_reg <= 6'h01;
                  half_cnt_reg <= 8'h00;
                  state_reg <= S_HIGH;
               end
            end

            // clock high: data stands while the receiver latches it
            S_HIGH: begin
               half_cnt_reg <= half_cnt_reg + 8'h01;
               if (half_done) begin
                  half_cnt_reg <= 8'h00;
                  if (frame_last) begin
                     // the last bit was held through the high half, then the new conversion is flagged
                     o_sdo <= 1'b1;
                     o_sck_out <= 1'b1;
                     o_cfg_word <= in_shift_reg;
                     o_cfg_valid <= 1'b1;
                     state_reg <= S_CONV;
                  end else begin
                     // each fall shows the next result bit, most significant first
                     o_sck_out <= 1'b0;
                     o_sdo <= out_shift_reg[`FRAME_BITS-2];
                     out_shift_reg <= {out_shift_reg[`FRAME_BITS-2:0], 1'b1};
                     state_reg <= S_LOW;
                  end
               end
            end

            // clock low: next rise samples the input and counts an edge
            // the output already moved on the fall; only the input is taken here
            S_LOW: begin
               half_cnt_reg <= half_cnt_reg + 8'h01;
               if (half_done) begin
                  o_sck_out <= 1'b1;
                  in_shift_reg <= shift_in(in_shift_reg, sdi_sync_reg);
                  rise_cnt_reg <= rise_cnt_reg + 6'h01;
                  half_cnt_reg <= 8'h00;
                  state_reg <= S_HIGH;
               end
            end

            // external clock mode is outside this block: release the pin, keep data high
            // no frame is ever started here; a new reset reads the strap again
            S_EXT: begin
               o_sck_oe <= 1'b0;
               o_sdo <= 1'b1;
            end

            // an unknown state parks both pins at idle and reads the strap again
            default: begin
               o_sck_out <= `PIN_IDLE;
               o_sck_oe <= 1'b0;
               o_sdo <= `PIN_IDLE;
               o_sleep <= 1'b0;
               strap_cnt_reg <= 2'h0;
               state_reg <= S_STRAP;
            end
         endcase
      end
   end

   // edges of the external oscillator, read from the second flop only
   // the delay flop resets to the synchroniser's level, so reset gives no false edge
   assign osc_edge = osc_sync_reg ^ osc_dly_reg;

   // front-end sampling strobe from the internal or the external oscillator
   always @(posedge i_clk) begin
      if (i_reset) begin
         osc_dly_reg <= 1'b0;
         sample_cnt_reg <= 10'h000;
         edge_cnt_reg <= 3'h0;
         o_sample_strobe <= 1'b0;
      end else begin
         osc_dly_reg <= osc_sync_reg;
         o_sample_strobe <= 1'b0;
         if (ext_sync_reg) begin
            // both edges counted, so half an oscillator cycle resolves exactly
            sample_cnt_reg <= 10'h000;
            if (osc_edge) begin
               if (edge_cnt_reg == EXT_LAST) begin
                  edge_cnt_reg <= 3'h0;
                  o_sample_strobe <= 1'b1;
               end else begin
                  edge_cnt_reg <= edge_cnt_reg + 3'h1;
               end
            end
         end else begin
            // period rounded down to whole clock cycles
            // the half cycle lost to rounding makes strobes about 0.05 percent early
            edge_cnt_reg <= 3'h0;
            if (sample_cnt_reg == SAMPLE_LAST) begin
               sample_cnt_reg <= 10'h000;
               o_sample_strobe <= 1'b1;
            end else begin
               sample_cnt_reg <= sample_cnt_reg + 10'h001;
            end
         end
      end
   end

endmodule // adc_readout_seq

//--- tb/adc_readout_seq_monitor.sv
// checker for the readout sequencer serial pins and status
// assumes it is bound to adc_readout_seq; one clock domain
`timescale 1ns/1ps
module adc_readout_seq_monitor (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // serial pins and status
   input wire logic o_sck_out,
   input wire logic o_sck_oe,
   input wire logic o_sdo,
   input wire logic o_sleep,
   input wire logic o_sample_strobe,
   input wire logic o_cfg_valid
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // pins idle high and no sleep in the first cycle after reset
   reset_idle_a: assert property ($past(i_reset) |-> o_sck_out && o_sdo && !o_sleep) else $error("pins not idle");
   sleep_pins_low_a: assert property (o_sleep |-> !o_sck_out && !o_sdo) else $error("sleep pins not low");
   sleep_min_a: assert property ($rose(o_sleep) |-> o_sleep[*8] ##1 o_sleep[*2]) else $error("sleep too short");
   sleep_exit_a: assert property ($rose(o_sleep) |-> ##10 (!o_sleep && o_sck_out)) else $error("no first rise");
   sck_driven_a: assert property (o_sleep |-> o_sck_oe) else $error("clock pin not driven");
   // data must hold still on each rise of the clock
   sdo_at_rise_a: assert property ($rose(o_sck_out) |-> $stable(o_sdo)) else $error("data moved at rise");
   low_half_a: assert property ($fell(o_sck_out) |-> !o_sck_out[*8] ##1 !o_sck_out[*2] ##1 o_sck_out)
      else $error("low half not ten cycles");
   frame_end_a: assert property (o_cfg_valid |-> (o_sdo && o_sck_out) ##1 !o_cfg_valid) else $error("bad frame end");
   strobe_pulse_a: assert property (o_sample_strobe |=> !o_sample_strobe[*8]) else $error("strobe too close");
   // main scenarios reached
   cover property ($rose(o_sleep));
   cover property (o_cfg_valid);
   cover property (o_sample_strobe);
endmodule // adc_readout_seq_monitor

//--- tb/frame_receiver.sv
// far-side controller: captures data on the device clock, sends a config word
// assumes pins arrive as levels in the system clock domain
`timescale 1ns/1ps
module frame_receiver (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // pins seen from the far side
   input wire logic i_sck,
   input wire logic i_sdo,
   output logic o_sdi,
   // words sent and received
   input wire logic [31:0] i_tx_word,
   output logic [31:0] o_rx_word,
   output logic o_rx_done
);
   logic sck_reg;
   int rise_cnt;
   // capture on rises, next config bit after each fall, junk between frames
   always @(posedge i_clk) begin
      sck_reg <= i_sck;
      o_rx_done <= 1'b0;
      if (i_reset) begin
         rise_cnt <= 32;
         o_sdi <= 1'b0;
      end else if (i_sck && !sck_reg) begin
         o_rx_word <= {o_rx_word[30:0], i_sdo};
         rise_cnt <= rise_cnt + 1;
         o_rx_done <= (rise_cnt == 31);
      end else if (!i_sck && sck_reg) begin
         rise_cnt <= (rise_cnt == 32) ? 0 : rise_cnt;
         o_sdi <= i_tx_word[(rise_cnt == 32) ? 31 : 31 - rise_cnt];
      end else if (rise_cnt == 32) begin
         o_sdi <= ~o_sdi; // line is not held outside a frame
      end
   end
endmodule // frame_receiver

//--- tb/adc_readout_seq_tb_top.sv
// self-checking bench for the continuous readout sequencer
// assumes the clock pin has a pull-up and chip select is grounded
`timescale 1ns/1ps
module adc_readout_seq_tb_top;
   logic i_clk = 1'b0, i_reset = 1'b1, i_result_valid = 1'b0, i_conv_osc_input = 1'b0, i_ext_osc_en = 1'b0;
   logic [30:0] i_result_data = 31'h0;
   logic [31:0] seed = 32'h00000011, tx_word = 32'h0000A5C3, rx_word, o_cfg_word;
   logic o_result_ready, o_sck_out, o_sck_oe, o_sdo, sdi, o_int_mode, o_sleep, o_sample_strobe, o_cfg_valid, rx_done;
   logic strap_low = 1'b0;
   wire sck_pin = o_sck_oe ? o_sck_out : !strap_low; // pull-up when released, unless held low for the strap
   logic [31:0] exp_q[$];
   int err_total = 0, comparisons = 0, cfg_cnt = 0, oc = 0, n, k;

   adc_readout_seq u_adc_readout_seq (.i_clk(i_clk), .i_reset(i_reset), .i_result_data(i_result_data),
      .i_result_valid(i_result_valid), .o_result_ready(o_result_ready), .i_sck_in(sck_pin), .o_sck_out(o_sck_out),
      .o_sck_oe(o_sck_oe), .o_sdo(o_sdo), .i_sdi(sdi), .i_conv_osc_input(i_conv_osc_input), .i_ext_osc_en(i_ext_osc_en),
      .o_int_mode(o_int_mode), .o_sleep(o_sleep), .o_sample_strobe(o_sample_strobe), .o_cfg_valid(o_cfg_valid),
      .o_cfg_word(o_cfg_word));
   frame_receiver u_frame_receiver (.i_clk(i_clk), .i_reset(i_reset), .i_sck(sck_pin), .i_sdo(o_sdo), .o_sdi(sdi),
      .i_tx_word(tx_word), .o_rx_word(rx_word), .o_rx_done(rx_done));

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // offer one word and hold it until the buffer takes it
   task automatic push(input logic [30:0] d);
      i_result_data <= d;
      i_result_valid <= 1'b1;
      exp_q.push_back({1'b0, d});
      for (k = 0; k < 4000 && !(k > 0 && o_result_ready === 1'b1); k++) @(posedge i_clk);
      if (k == 4000) begin
         err_total++;
         give_verdict();
      end
   endtask
   task automatic wait_cfg(input int target);
      for (k = 0; k < 4000 && cfg_cnt < target; k++) @(posedge i_clk);
      if (k == 4000) begin
         err_total++;
         give_verdict();
      end
   endtask
   // cycles between two sampling strobes
   task automatic gap(output int g);
      for (k = 0; k < 2000 && o_sample_strobe !== 1'b1; k++) @(posedge i_clk);
      if (k == 2000) begin
         err_total++;
         give_verdict();
      end
      @(posedge i_clk);
      for (g = 1; g < 2000 && o_sample_strobe !== 1'b1; g++) @(posedge i_clk);
   endtask

   initial begin
      forever #4 i_clk = ~i_clk;
   end
   // external oscillator toggles every third cycle
   always @(posedge i_clk) begin
      oc <= (oc == 2) ? 0 : oc + 1;
      if (oc == 2) i_conv_osc_input <= ~i_conv_osc_input;
   end
   // reference model: every frame gives the flag bit then the queued result
   always @(posedge i_clk) begin
      if (rx_done === 1'b1) chk(exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF, rx_word);
      if (o_cfg_valid === 1'b1) begin
         chk(tx_word, o_cfg_word);
         tx_word <= xorshift(tx_word);
         cfg_cnt <= cfg_cnt + 1;
      end
   end

   initial begin
      for (n = 0; n < 16; n++) @(posedge i_clk);
      i_reset <= 1'b0;
      for (n = 0; n < 8; n++) @(posedge i_clk);
      chk(32'h1, 32'(o_int_mode & o_sck_oe));
      seed = xorshift(seed);
      push(seed[30:0]);
      i_result_valid <= 1'b0;
      wait_cfg(1);
      $display("single frame done");
      for (n = 0; n < 3; n++) begin
         seed = xorshift(seed);
         push(seed[30:0]);
      end
      i_result_valid <= 1'b0;
      wait_cfg(4);
      $display("back to back frames done");
      chk(32'h1, 32'(o_sdo & o_sck_out));
      gap(n);
      chk(32'd1012, 32'(n));
      i_ext_osc_en <= 1'b1;
      for (n = 0; n < 60; n++) @(posedge i_clk);
      gap(n);
      chk(32'd15, 32'(n));
      $display("sampling strobe done");
      // second reset in mid-run with the clock pin held low: external mode, pin released
      i_reset <= 1'b1;
      for (n = 0; n < 2; n++) @(posedge i_clk);
      strap_low <= 1'b1;
      for (n = 0; n < 4; n++) @(posedge i_clk);
      i_reset <= 1'b0;
      for (n = 0; n < 8; n++) @(posedge i_clk);
      chk(32'h0, 32'(o_int_mode));
      chk(32'h0, 32'(o_sck_oe));
      chk(32'h1, 32'(o_sdo & o_sck_out));
      $display("clock pin strap done");
      give_verdict();
   end
endmodule // adc_readout_seq_tb_top

bind adc_readout_seq adc_readout_seq_monitor u_adc_readout_seq_monitor (.i_clk(i_clk), .i_reset(i_reset),
   .o_sck_out(o_sck_out), .o_sck_oe(o_sck_oe), .o_sdo(o_sdo), .o_sleep(o_sleep), .o_sample_strobe(o_sample_strobe),
   .o_cfg_valid(o_cfg_valid));
